// *** logic/ccrc_bus.sv ***
// Purpose: One asynchronous flash bus cycle, read or write, per request
// Assumes: Request held until ack; data pins synchronised before use
// Notes: Byte mode drives the byte address LSB on the shared data pin
`timescale 1ns/1ps
module ccrc_bus #(
    parameter int ADDR_W = 25
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Request side
    input wire logic req,
    input wire logic wr,
    input wire logic [ADDR_W:0] baddr,
    input wire logic byte_mode,
    input wire logic [15:0] wdata,
    output logic ack,
    output logic [15:0] rdata,
    // Flash pins
    output logic [ADDR_W-1:0] flash_addr,
    output logic flash_ce_b,
    output logic flash_we_b,
    output logic flash_re_b,
    output logic flash_byte_b,
    output logic [15:0] dq_o,
    output logic [15:0] dq_oe_b,
    input wire logic [15:0] dq_i
);
    import ccrc_pkg::*;

    localparam logic [CNT_W-1:0] STROBE_N = CNT_W'(STROBE_CYC - 1);
    localparam logic [CNT_W-1:0] READ_N = CNT_W'(ACCESS_CYC + SYNC_CYC - 1);
    localparam logic [CNT_W-1:0] GAP_N = CNT_W'(GAP_CYC - 1);

    if (ACCESS_CYC + SYNC_CYC >= (1 << CNT_W)) begin : g_chk
        $error("Bus cycle counts exceed counter width");
    end

    typedef enum logic [2:0] {
        B_IDLE, B_SETUP, B_STROBE, B_HOLD, B_GAP
    } ccrc_bst_e;

    typedef struct packed {
        ccrc_bst_e st;
        logic [CNT_W-1:0] cnt;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [15:0] dq_o;
        logic [15:0] oe_b;
        logic ce_b;
        logic we_b;
        logic re_b;
        logic byte_b;
        logic ack;
        logic [15:0] rdata;
        logic [15:0] s1;
        logic [15:0] s2;
    } ccrc_bus_s;

    ccrc_bus_s b_q, b_d;

    always_comb begin
        b_d = b_q;
        b_d.ack = 1'b0;
        b_d.s1 = dq_i;
        b_d.s2 = b_q.s1;
        b_d.byte_b = ~byte_mode;
        unique case (b_q.st)
            B_IDLE: begin
                // Byte mode owns the shared pin; word mode only on writes
                b_d.oe_b[SHARED_BIT] = ~byte_mode;
                if (req && !b_q.ack) begin
                    b_d.st = B_SETUP;
                    b_d.wr = wr;
                    b_d.addr = baddr[ADDR_W:1];
                    b_d.ce_b = 1'b0;
                    if (byte_mode) begin
                        b_d.dq_o = {baddr[0], 7'h00, wdata[7:0]};
                        b_d.oe_b[14:0] = wr ? 15'h7F00 : 15'h7FFF;
                    end else begin
                        b_d.dq_o = wdata;
                        b_d.oe_b = wr ? 16'h0000 : 16'hFFFF;
                    end
                end
            end
            B_SETUP: begin
                b_d.st = B_STROBE;
                b_d.cnt = b_q.wr ? STROBE_N : READ_N;
                b_d.we_b = ~b_q.wr;
                b_d.re_b = b_q.wr;
            end
            B_STROBE: begin
                if (b_q.cnt == '0) begin
                    b_d.st = B_HOLD;
                    b_d.we_b = 1'b1;
                    b_d.re_b = 1'b1;
                    b_d.rdata = b_q.s2;
                end else begin
                    b_d.cnt = b_q.cnt - 1'b1;
                end
            end
            B_HOLD: begin
                b_d.st = B_GAP;
                b_d.cnt = GAP_N;
                b_d.ce_b = 1'b1;
                b_d.oe_b[14:0] = 15'h7FFF;
                if (!byte_mode) begin
                    b_d.oe_b[SHARED_BIT] = 1'b1;
                end
            end
            B_GAP: begin
                if (b_q.cnt == '0) begin
                    b_d.st = B_IDLE;
                    b_d.ack = 1'b1;
                end else begin
                    b_d.cnt = b_q.cnt - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            b_q <= '0;
            b_q.st <= B_IDLE;
            b_q.oe_b <= 16'hFFFF;
            b_q.ce_b <= 1'b1;
            b_q.we_b <= 1'b1;
            b_q.re_b <= 1'b1;
            b_q.byte_b <= 1'b1;
        end else begin
            b_q <= b_d;
        end
    end

    assign ack = b_q.ack;
    assign rdata = b_q.rdata;
    assign flash_addr = b_q.addr;
    assign flash_ce_b = b_q.ce_b;
    assign flash_we_b = b_q.we_b;
    assign flash_re_b = b_q.re_b;
    assign flash_byte_b = b_q.byte_b;
    assign dq_o = b_q.dq_o;
    assign dq_oe_b = b_q.oe_b;
endmodule // ccrc_bus

// *** logic/ccrc_host.sv ***
// Purpose: Host sequencer issuing the flash CRC-64 check and polling result
// Assumes: Flash on the pins below; start pulses only while not busy
// Notes: Ready is taken from the toggle bit of two successive status reads
// Behaviour
// - The host writes the two unlock cycles and then the extended code EB.
// - For a range the host writes sub-op 27, count 0A/15 and option FFFE.
// - The host writes the expected CRC as four words, low word first.
// - The host writes the start byte address low then high, then a zero.
// - The host writes the stop byte address low then high, then a zero.
// - Confirm 29 starts the check and the host polls until ready.
// - For the whole array the host writes count 04/09, option FFFF, no range.
`timescale 1ns/1ps
module ccrc_host #(
    parameter int ADDR_W = 25
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // User request
    input wire logic start,
    input wire logic whole_array,
    input wire logic byte_mode,
    input wire logic [63:0] exp_crc,
    input wire logic [31:0] range_start,
    input wire logic [31:0] range_stop,
    // User result
    output logic busy,
    output logic done,
    output logic pass,
    output logic check_error_flag,
    // Flash pins
    output logic [ADDR_W-1:0] flash_addr,
    output logic flash_ce_b,
    output logic flash_we_b,
    output logic flash_re_b,
    output logic flash_byte_b,
    output logic [15:0] dq_o,
    output logic [15:0] dq_oe_b,
    input wire logic [15:0] dq_i
);
    import ccrc_pkg::*;

    if (ADDR_W < 12) begin : g_chk
        $error("Address width too small for unlock addresses");
    end

    typedef enum logic [1:0] {S_IDLE, S_WR, S_POLL} ccrc_st_e;

    typedef struct packed {
        ccrc_st_e st;
        logic [4:0] step;
        logic half;
        logic [1:0] poll_n;
        logic [15:0] last;
        logic whole;
        logic bmode;
        logic [63:0] crc;
        logic [31:0] sa;
        logic [31:0] sp;
        logic req;
        logic busy;
        logic done;
        logic pass;
        logic err;
    } ccrc_host_s;

    ccrc_host_s s_q, s_d;
    logic bus_req;
    logic bus_wr;
    logic [ADDR_W:0] bus_baddr;
    logic [15:0] bus_wdata;
    logic bus_ack;
    logic [15:0] bus_rdata;
    logic multi;

    // Word written at a step, before byte selection
    function automatic logic [15:0] step_word(input ccrc_host_s s);
        logic [15:0] w;
        w = RSVD_WORD;
        unique case (s.step)
            STEP_UNLK1: w = UNLK1_DATA;
            STEP_UNLK2: w = UNLK2_DATA;
            STEP_EXT: w = EXT_CMD;
            STEP_SUBOP: w = SUBOP_CRC;
            STEP_COUNT: w = s.whole ? (s.bmode ? CNT_WHOLE_B : CNT_WHOLE_W)
                                    : (s.bmode ? CNT_RANGE_B : CNT_RANGE_W);
            STEP_WORD0: w = s.whole ? OPT_WHOLE : OPT_RANGE;
            STEP_SA_LO: w = s.sa[15:0];
            STEP_SA_HI: w = s.sa[31:16];
            STEP_SP_LO: w = s.sp[15:0];
            STEP_SP_HI: w = s.sp[31:16];
            STEP_CONFIRM: w = CONFIRM_CMD;
            default: begin
                if (s.step >= STEP_CRC0 && s.step <= STEP_CRC3) begin
                    w = s.crc[16 * (s.step - STEP_CRC0) +: 16];
                end
            end
        endcase
        return w;
    endfunction

    // Byte address of a step; word mode keeps a zero LSB
    function automatic logic [ADDR_W:0] step_addr(input ccrc_host_s s);
        logic [ADDR_W:0] a;
        logic [4:0] off;
        a = '0;
        off = s.step - STEP_WORD0;
        if (s.st == S_WR) begin
            if (s.step == STEP_UNLK1) begin
                a = s.bmode ? (ADDR_W+1)'(UNLK1_BADDR)
                            : (ADDR_W+1)'({UNLK1_WADDR, 1'b0});
            end else if (s.step == STEP_UNLK2) begin
                a = s.bmode ? (ADDR_W+1)'(UNLK2_BADDR)
                            : (ADDR_W+1)'({UNLK2_WADDR, 1'b0});
            end else if (s.step >= STEP_WORD0 && s.step < STEP_CONFIRM) begin
                a = (ADDR_W+1)'({off, s.half});
            end
        end
        return a;
    endfunction

    assign multi = s_q.bmode && s_q.step >= STEP_WORD0
                   && s_q.step != STEP_CONFIRM;
    assign bus_req = s_q.req;
    assign bus_wr = (s_q.st == S_WR);
    assign bus_baddr = step_addr(s_q);
    // Low byte before high byte of each word in byte mode
    assign bus_wdata = !s_q.bmode ? step_word(s_q)
                       : {8'h00, (multi && s_q.half) ? step_word(s_q)[15:8]
                                                     : step_word(s_q)[7:0]};

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        unique case (s_q.st)
            S_IDLE: begin
                if (start) begin
                    s_d.st = S_WR;
                    s_d.step = STEP_UNLK1;
                    s_d.half = 1'b0;
                    s_d.whole = whole_array;
                    s_d.bmode = byte_mode;
                    s_d.crc = exp_crc;
                    s_d.sa = range_start;
                    s_d.sp = range_stop;
                    s_d.req = 1'b1;
                    s_d.busy = 1'b1;
                    s_d.pass = 1'b0;
                    s_d.err = 1'b0;
                end
            end
            S_WR: begin
                if (bus_ack) begin
                    if (multi && !s_q.half) begin
                        s_d.half = 1'b1;
                    end else if (s_q.step == STEP_CONFIRM) begin
                        s_d.st = S_POLL;
                        s_d.poll_n = 2'd0;
                    end else begin
                        s_d.half = 1'b0;
                        // Whole array skips the range words
                        s_d.step = (s_q.whole && s_q.step == STEP_CRC3)
                                   ? STEP_CONFIRM : s_q.step + 5'd1;
                    end
                end
            end
            S_POLL: begin
                // Every read returns status while running
                if (bus_ack) begin
                    unique case (s_q.poll_n)
                        2'd0, 2'd2: begin
                            s_d.last = bus_rdata;
                            s_d.poll_n = s_q.poll_n + 2'd1;
                        end
                        2'd1: begin
                            if (bus_rdata[STAT_TOGGLE_BIT]
                                == s_q.last[STAT_TOGGLE_BIT]) begin
                                s_d.st = S_IDLE;
                                s_d.pass = 1'b1;
                            end else if (bus_rdata[STAT_ERR_BIT]) begin
                                s_d.poll_n = 2'd2;
                            end else begin
                                s_d.last = bus_rdata;
                            end
                        end
                        2'd3: begin
                            s_d.st = S_IDLE;
                            // Still toggling with error set means failure
                            if (bus_rdata[STAT_TOGGLE_BIT]
                                != s_q.last[STAT_TOGGLE_BIT]) begin
                                s_d.err = 1'b1;
                            end else begin
                                s_d.pass = 1'b1;
                            end
                        end
                    endcase
                    if (s_d.st == S_IDLE) begin
                        s_d.req = 1'b0;
                        s_d.busy = 1'b0;
                        s_d.done = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.st <= S_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    ccrc_bus #(
        .ADDR_W(ADDR_W)
    ) u_bus (
        .clk(clk),
        .rst_b(rst_b),
        .req(bus_req),
        .wr(bus_wr),
        .baddr(bus_baddr),
        .byte_mode(s_q.bmode),
        .wdata(bus_wdata),
        .ack(bus_ack),
        .rdata(bus_rdata),
        .flash_addr(flash_addr),
        .flash_ce_b(flash_ce_b),
        .flash_we_b(flash_we_b),
        .flash_re_b(flash_re_b),
        .flash_byte_b(flash_byte_b),
        .dq_o(dq_o),
        .dq_oe_b(dq_oe_b),
        .dq_i(dq_i)
    );

    assign busy = s_q.busy;
    assign done = s_q.done;
    assign pass = s_q.pass;
    assign check_error_flag = s_q.err;

    a_unlock_first: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(s_q.busy) |-> ##1 bus_req && bus_wr
        && bus_wdata == UNLK1_DATA && bus_baddr[11:0] == (s_q.bmode
        ? UNLK1_BADDR : {UNLK1_WADDR[10:0], 1'b0}))
        else $error("first unlock write wrong");

    a_range_count: assert property (@(posedge clk) disable iff (!rst_b)
        bus_ack && bus_wr && s_q.step == STEP_SUBOP && !s_q.whole |=>
        bus_wdata == (s_q.bmode ? CNT_RANGE_B : CNT_RANGE_W))
        else $error("range count value wrong");

    a_crc_high_byte: assert property (@(posedge clk) disable iff (!rst_b)
        bus_ack && bus_wr && s_q.step == STEP_CRC0 && s_q.bmode
        && !s_q.half |=> bus_wdata == {8'h00, s_q.crc[15:8]}
        && bus_baddr[4:0] == 5'h03)
        else $error("crc high byte not after low byte");

    a_start_word: assert property (@(posedge clk) disable iff (!rst_b)
        bus_ack && bus_wr && s_q.step == STEP_CRC3 && !s_q.bmode
        && !s_q.whole |=> bus_wdata == s_q.sa[15:0]
        && bus_baddr[4:0] == 5'h0A)
        else $error("start address word wrong");

    a_stop_rsvd: assert property (@(posedge clk) disable iff (!rst_b)
        bus_req && bus_wr && s_q.step == STEP_RSV2 |-> bus_wdata == RSVD_WORD)
        else $error("reserved word after stop not zero");

    a_confirm_poll: assert property (@(posedge clk) disable iff (!rst_b)
        bus_ack && bus_wr && s_q.step == STEP_CONFIRM |=>
        s_q.st == S_POLL && bus_req && !bus_wr && s_q.busy)
        else $error("no polling after confirm");

    a_whole_skip: assert property (@(posedge clk) disable iff (!rst_b)
        bus_ack && bus_wr && s_q.whole && s_q.step == STEP_CRC3
        && (!s_q.bmode || s_q.half) |=> s_q.step == STEP_CONFIRM)
        else $error("whole array did not skip range words");
endmodule // ccrc_host

// *** logic/ccrc_pkg.sv ***
// Purpose: Constants for the CRC-64 check sequencer that drives a NOR flash
// Assumes: 100 MHz clock, asynchronous flash bus cycles
// Notes: Bus timing figures are plain defaults, tune per part
package ccrc_pkg;
    localparam int CLK_NS = 10;
    // Bus cycle times in ns, converted to whole cycles rounded up
    localparam int T_STROBE_NS = 40;
    localparam int T_ACCESS_NS = 120;
    localparam int T_GAP_NS = 20;
    localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_CYC = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_CYC = 2;
    localparam int CNT_W = 8;

    // Command addresses, word mode and byte mode
    localparam logic [11:0] UNLK1_WADDR = 12'h555;
    localparam logic [11:0] UNLK1_BADDR = 12'hAAA;
    localparam logic [11:0] UNLK2_WADDR = 12'h2AA;
    localparam logic [11:0] UNLK2_BADDR = 12'h555;

    // Command data
    localparam logic [15:0] UNLK1_DATA = 16'h00AA;
    localparam logic [15:0] UNLK2_DATA = 16'h0055;
    localparam logic [15:0] EXT_CMD = 16'h00EB;
    localparam logic [15:0] SUBOP_CRC = 16'h0027;
    localparam logic [15:0] CNT_RANGE_W = 16'h000A;
    localparam logic [15:0] CNT_RANGE_B = 16'h0015;
    localparam logic [15:0] CNT_WHOLE_W = 16'h0004;
    localparam logic [15:0] CNT_WHOLE_B = 16'h0009;
    localparam logic [15:0] OPT_RANGE = 16'hFFFE;
    localparam logic [15:0] OPT_WHOLE = 16'hFFFF;
    localparam logic [15:0] RSVD_WORD = 16'h0000;
    localparam logic [15:0] CONFIRM_CMD = 16'h0029;

    // Sequence steps; steps STEP_WORD0 to STEP_RSV2 carry word offset step-5
    localparam logic [4:0] STEP_UNLK1 = 5'h00;
    localparam logic [4:0] STEP_UNLK2 = 5'h01;
    localparam logic [4:0] STEP_EXT = 5'h02;
    localparam logic [4:0] STEP_SUBOP = 5'h03;
    localparam logic [4:0] STEP_COUNT = 5'h04;
    localparam logic [4:0] STEP_WORD0 = 5'h05;
    localparam logic [4:0] STEP_CRC0 = 5'h06;
    localparam logic [4:0] STEP_CRC3 = 5'h09;
    localparam logic [4:0] STEP_SA_LO = 5'h0A;
    localparam logic [4:0] STEP_SA_HI = 5'h0B;
    localparam logic [4:0] STEP_RSV1 = 5'h0C;
    localparam logic [4:0] STEP_SP_LO = 5'h0D;
    localparam logic [4:0] STEP_SP_HI = 5'h0E;
    localparam logic [4:0] STEP_RSV2 = 5'h0F;
    localparam logic [4:0] STEP_CONFIRM = 5'h10;

    // Polling status bits and the shared data pin bit
    localparam int STAT_TOGGLE_BIT = 6;
    localparam int STAT_ERR_BIT = 5;
    localparam int SHARED_BIT = 15;
endpackage

// *** sim/ccrc_flash_model.sv ***
// Purpose: Behavioural NOR flash answering the CRC-64 check sequence
// Assumes: Small array, host polls status at address 0 only
// Notes: Undriven data bits are resolved by the bench
`timescale 1ns/1ps
module ccrc_flash_model #(
    parameter int ADDR_W = 25,
    parameter int MEM_BYTES = 64,
    parameter int BUSY_NS = 2000,
    parameter int ACC_NS = 90
) (
    // Flash pins
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic flash_ce_b,
    input wire logic flash_we_b,
    input wire logic flash_re_b,
    input wire logic flash_byte_b,
    input wire logic [15:0] dq_i,
    // Device drive, low enable drives
    output logic [15:0] dq_f,
    output logic [15:0] dq_f_oe_b,
    // Board reset
    input wire logic hw_rst_b
);
    localparam logic [63:0] POLY = 64'h42F0_E1EB_A9EA_3693;
    logic [47:0] wr_log [$];
    logic [15:0] wd [11];
    int stp = 0;
    logic bm = 1'b0, whole = 1'b0, run = 1'b0, err = 1'b0;
    logic tog = 1'b0, valid = 1'b0;
    time end_t = 0;

    function automatic logic [7:0] mem(int i);
        return 8'(i * 37 + 5);
    endfunction

    function automatic logic [63:0] crc_of(int lo, int hi);
        logic [63:0] c;
        c = '0;
        for (int i = lo; i <= hi; i++) begin
            for (int b = 0; b < 8; b++) begin
                c = {c[62:0], 1'b0} ^ ((c[63] ^ mem(i)[b]) ? POLY : '0);
            end
        end
        return c;
    endfunction

    task automatic launch();
        int s, e;
        s = whole ? 0 : int'({wd[6], wd[5]});
        e = whole ? MEM_BYTES - 1 : int'({wd[9], wd[8]});
        if (e > s) begin
            err = crc_of(s, e)
                != {wd[4], wd[3], wd[2], wd[1]};
            run = 1'b1;
            tog = 1'b0;
            end_t = $time + BUSY_NS + 40 * (e - s);
        end
    endtask

    task automatic step(logic [31:0] a, logic [15:0] d);
        int n, k, kw;
        logic ok;
        n = (whole ? 5 : 11) * (bm ? 2 : 1);
        k = stp - 5;
        kw = bm ? k / 2 : k;
        case (stp)
            0: ok = a == (bm ? 32'hAAA : 32'h555)
                && d == 16'h00AA;
            1: ok = a == (bm ? 32'h555 : 32'h2AA)
                && d == 16'h0055;
            2: ok = a == 0 && d == 16'h00EB;
            3: ok = a == 0 && d == 16'h0027;
            4: begin
                whole = d == (bm ? 16'h0009 : 16'h0004);
                ok = a == 0 && (whole || d == (bm ? 16'h0015 : 16'h000A));
            end
            default: ok = a == (k < n ? k : 0);
        endcase
        if (stp > 4 && k < n) begin
            if (!bm) wd[kw] = d;
            else if (k[0]) wd[kw][15:8] = d[7:0];
            else wd[kw][7:0] = d[7:0];
            if (kw == 0 && (!bm || k[0]))
                ok = ok && wd[0] == (whole ? 16'hFFFF : 16'hFFFE);
            if ((kw == 7 || kw == 10) && (!bm || k[0]))
                ok = ok && wd[kw] == 16'h0000;
        end
        if (stp > 4 && k == n) begin
            if (ok && d == 16'h0029) launch();
            ok = 1'b0;
        end
        stp = ok ? stp + 1 : 0;
    endtask

    always @(posedge flash_we_b) begin : wr_cap
        logic [31:0] a;
        logic [15:0] d;
        if (!flash_ce_b) begin
            bm = !flash_byte_b;
            a = bm ? 32'({flash_addr, dq_i[15]})
                : 32'(flash_addr);
            d = bm ? {8'h00, dq_i[7:0]} : dq_i;
            wr_log.push_back({a, d});
            if (!run && !err) step(a, d);
        end
    end

    always @(negedge flash_re_b) begin
        valid = 1'b0;
        if (run && $time >= end_t) run = 1'b0;
        if (!flash_ce_b && (run || err)) tog = ~tog;
        #(ACC_NS);
        valid = !flash_re_b && !flash_ce_b;
    end
    always @(posedge flash_re_b) valid = 1'b0;

    always @* begin
        dq_f_oe_b = (valid && !flash_re_b) ?
            (flash_byte_b ? 16'h0000 : 16'hFF00) : 16'hFFFF;
        if (run || err) dq_f = {9'h000, tog, err && !run,
            5'h00};
        else dq_f = flash_byte_b ? {mem(1), mem(0)} : {8'h00, mem(0)};
    end

    always @(negedge hw_rst_b) begin
        stp = 0;
        run = 1'b0;
        err = 1'b0;
    end
endmodule // ccrc_flash_model

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the CRC-64 check sequencer
// Assumes: Flash model on the pins, one clock
// Notes: Bus writes are compared with a reference list
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, rst_b = 1'b0, hw_rst_b = 1'b1, start = 1'b0;
    logic whole_array = 1'b0, byte_mode = 1'b0;
    logic [63:0] exp_crc = '0;
    logic [31:0] range_start = '0, range_stop = '0;
    logic busy, done, pass, check_error_flag;
    logic flash_ce_b, flash_we_b, flash_re_b, flash_byte_b;
    logic [24:0] flash_addr;
    logic [15:0] dq_o, dq_oe_b, dq_f, dq_f_oe_b, dq_i;
    logic [15:0] dq_last = '0;
    logic [47:0] ref_q [$];
    int n_errors = 0, num_checks = 0;

    always #5 clk = ~clk;
    // Wire level: host, then flash, else a changing pattern
    assign dq_i = (~dq_oe_b & dq_o) | (dq_oe_b & ~dq_f_oe_b & dq_f)
        | (dq_oe_b & dq_f_oe_b & ~dq_last);
    always @(posedge clk) dq_last <= dq_i;

    ccrc_host u_ccrc_host (.*);
    ccrc_flash_model u_ccrc_flash_model (.*);

    task automatic chk(logic [63:0] got, logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic put(logic [31:0] a, logic [15:0] d);
        ref_q.push_back({a, d});
    endtask

    task automatic build(bit wh, bit bm, logic [63:0] x,
        logic [31:0] s, logic [31:0] e);
        logic [15:0] w [11];
        ref_q = {};
        w = '{wh ? 16'hFFFF : 16'hFFFE, x[15:0], x[31:16], x[47:32],
            x[63:48], s[15:0], s[31:16], 16'h0000, e[15:0], e[31:16],
            16'h0000};
        put(bm ? 32'hAAA : 32'h555, 16'h00AA);
        put(bm ? 32'h555 : 32'h2AA, 16'h0055);
        put(32'h0, 16'h00EB);
        put(32'h0, 16'h0027);
        put(32'h0, wh ? (bm ? 16'h0009 : 16'h0004)
            : (bm ? 16'h0015 : 16'h000A));
        for (int k = 0; k <= (wh ? 4 : 10); k++) begin
            if (bm) begin
                put(32'(2 * k), {8'h00, w[k][7:0]});
                put(32'(2 * k + 1), {8'h00, w[k][15:8]});
            end else begin
                put(32'(k), w[k]);
            end
        end
        put(32'h0, 16'h0029);
    endtask

    task automatic run(bit wh, bit bm, bit bad, bit same);
        int s, e, k;
        logic [63:0] c;
        logic ep;
        logic [47:0] lg [$];
        s = $urandom_range(30, 0);
        e = same ? s : s + $urandom_range(30, 1);
        c = wh ? u_ccrc_flash_model.crc_of(0, 63)
            : u_ccrc_flash_model.crc_of(s, e);
        if (bad) c = c ^ (64'h1 << $urandom_range(63, 0));
        ep = !bad || (!wh && same);
        build(wh, bm, c, s, e);
        u_ccrc_flash_model.wr_log = {};
        @(posedge clk);
        whole_array <= wh;
        byte_mode <= bm;
        exp_crc <= c;
        range_start <= s;
        range_stop <= e;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        chk(busy, 1);
        // Second start while busy must be ignored
        start <= 1'b1;
        whole_array <= !wh;
        @(posedge clk);
        start <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 5000) begin
            @(posedge clk);
            k++;
        end
        chk(done, 1);
        chk(pass, ep);
        chk(check_error_flag, !ep);
        lg = u_ccrc_flash_model.wr_log;
        chk(lg.size(), ref_q.size());
        foreach (ref_q[i]) begin
            if (i < lg.size()) begin
                chk(lg[i], ref_q[i]);
            end
        end
        @(posedge clk);
        chk(done, 0);
        if (!ep) begin
            hw_rst_b <= 1'b0;
            @(posedge clk);
            hw_rst_b <= 1'b1;
        end
    endtask

    task automatic report_and_stop();
        $display("mismatches=%0d checks=%0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(32'h75DF43A3));
        repeat (6) @(posedge clk);
        chk(flash_ce_b, 1);
        chk(dq_oe_b, 16'hFFFF);
        chk(busy, 0);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            run(i[0], i[1], i[2], 1'b0);
        end
        run(1'b0, 1'b0, 1'b1, 1'b1);
        run(1'b0, 1'b1, 1'b1, 1'b1);
        report_and_stop();
    end

    initial begin
        #600000;
        n_errors++;
        report_and_stop();
    end
endmodule // tb
